// file: hdl/sensor_defs.svh
// Operation
// - Clock-stretching measurement: hold SCL low until measurement ends, then release.
// - Acknowledge a poll only when finished; master retries after a not-acknowledge.
// - Two result LSBs carry status: upper is type, 1 = humidity; lower zero.
// - Master not-acknowledge after second byte suppresses checksum; acknowledge sends it.
// - Measurement ends within the maximum time for its type and resolution.
// - Repeated Start accepted without Stop; Stop before next Start accepted too.
// - Soft reset restores defaults except heater; ready again under 15 ms.
// - User bits 7 and 0 select humidity and temperature resolution; default 00.
// - User bit 6 flags low supply, read-only, refreshed after each measurement.
// - User bit 2 enables heater; resets to 0; survives soft reset and reload.
// - User bit 1 low reloads defaults, heater excepted, on each measurement command.
// - Each result carries a CRC-8 with polynomial x^8 + x^5 + x^4 + 1.
// - Results go as two bytes MSB first, each byte followed by acknowledge.
// - Device answers fixed 7-bit address; direction bit 1 read, 0 write.
// - Device decodes measurement, user register read and write, soft reset commands.
`ifndef SENSOR_DEFS_SVH
`define SENSOR_DEFS_SVH

`define DEV_ADDR        7'h40
`define CMD_T_HOLD      8'he3
`define CMD_H_HOLD      8'he5
`define CMD_T_POLL      8'hf3
`define CMD_H_POLL      8'hf5
`define CMD_WR_UREG     8'he6
`define CMD_RD_UREG     8'he7
`define CMD_SRST        8'hfe

`define UREG_RST        8'h02
`define UREG_RSVD_DEF   3'h0
`define UREG_RES_HI_BIT 7
`define UREG_HEATER_BIT 2
`define UREG_NORLD_BIT  1
`define UREG_RES_LO_BIT 0

`define CRC_POLY        8'h31
`define CRC_INIT        8'h00

`define CLK_KHZ         50000
`define CYC_OF_MS(ms)   ((ms) * `CLK_KHZ)
`define T14_MAX_MS      85
`define T13_MAX_MS      43
`define T12_MAX_MS      22
`define T11_MAX_MS      11
`define H12_MAX_MS      29
`define H11_MAX_MS      15
`define H10_MAX_MS      9
`define H8_MAX_MS       4
`define SRST_MAX_MS     15
`define SDA_SETUP_NS    100
`define SDA_SETUP_CYC   ((`SDA_SETUP_NS * `CLK_KHZ + 999999) / 1000000)

`endif

// file: hdl/sensor_pkg.sv
`default_nettype none
package sensor_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK   = 3'b010,
    ST_CMD   = 3'b011,
    ST_WDATA = 3'b100,
    ST_TX    = 3'b101,
    ST_RACK  = 3'b110,
    ST_HOLD  = 3'b111
  } i2c_state_e;

  typedef struct packed {
    logic       res_hi;
    logic       low_supply;
    logic [2:0] rsvd;
    logic       heater;
    logic       no_reload;
    logic       res_lo;
  } user_reg_s;

  typedef struct packed {
    logic [15:0] word;
    logic [7:0]  crc;
  } result_s;
endpackage
`default_nettype wire

// file: hdl/crc8_unit.sv
`include "sensor_defs.svh"
`default_nettype none
module crc8_unit (
  input  wire logic [15:0] i_word,
  output logic      [7:0]  o_crc
);
  always_comb begin
    o_crc = `CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (o_crc[7] ^ i_word[i]) begin
        o_crc = {o_crc[6:0], 1'b0} ^ `CRC_POLY;
      end else begin
        o_crc = {o_crc[6:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/meas_timer.sv
`default_nettype none
module meas_timer (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic [22:0] i_cycles,
  output logic             o_busy,
  output logic             o_done
);
  logic [22:0] cnt_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 23'h000000;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt_reg <= i_cycles;
        o_busy  <= 1'b1;
      end else if (o_busy) begin
        if (cnt_reg <= 23'h000001) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 23'h000001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/humidity_temp_sensor_i2c_readout.sv
`include "sensor_defs.svh"
`default_nettype none
module humidity_temp_sensor_i2c_readout #(
  parameter int unsigned T14_CYC  = `CYC_OF_MS(`T14_MAX_MS),
  parameter int unsigned T13_CYC  = `CYC_OF_MS(`T13_MAX_MS),
  parameter int unsigned T12_CYC  = `CYC_OF_MS(`T12_MAX_MS),
  parameter int unsigned T11_CYC  = `CYC_OF_MS(`T11_MAX_MS),
  parameter int unsigned H12_CYC  = `CYC_OF_MS(`H12_MAX_MS),
  parameter int unsigned H11_CYC  = `CYC_OF_MS(`H11_MAX_MS),
  parameter int unsigned H10_CYC  = `CYC_OF_MS(`H10_MAX_MS),
  parameter int unsigned H8_CYC   = `CYC_OF_MS(`H8_MAX_MS),
  parameter int unsigned SRST_CYC = `CYC_OF_MS(`SRST_MAX_MS) - 1
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_scl,
  output logic             o_scl_out,
  output logic             o_scl_oe,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  input  wire logic [13:0] i_temp_code,
  input  wire logic [13:0] i_hum_code,
  input  wire logic        i_low_supply,
  output logic             o_heater_en,
  output logic             o_busy
);
  localparam logic [3:0] SETUP_CYC = 4'(`SDA_SETUP_CYC);

  logic                   rst_meta_reg;
  logic                   rst_n;
  logic                   scl_meta_reg;
  logic                   scl_reg;
  logic                   scl_prev_reg;
  logic                   sda_meta_reg;
  logic                   sda_reg;
  logic                   sda_prev_reg;
  logic                   ls_meta_reg;
  logic                   ls_reg;

  sensor_pkg::i2c_state_e state_reg;
  sensor_pkg::i2c_state_e after_reg;
  logic [3:0]             bit_cnt_reg;
  logic [7:0]             shift_reg;
  logic [1:0]             byte_idx_reg;
  logic [1:0]             last_idx_reg;
  logic                   tx_ureg_reg;
  logic                   mack_reg;
  logic [3:0]             guard_reg;

  sensor_pkg::user_reg_s  ureg_reg;
  sensor_pkg::result_s    res_reg;
  logic                   res_valid_reg;
  logic                   hold_pend_reg;
  logic                   rd_ureg_pend_reg;
  logic                   srst_reg;
  logic                   meas_hum_reg;
  logic [1:0]             meas_res_reg;

  logic                   timer_busy;
  logic                   timer_done;
  logic [22:0]            timer_cycles;
  logic [15:0]            cap_word;
  logic [7:0]             cap_crc;

  // reset release through two flops
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta_reg <= 1'b1;
      scl_reg      <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_reg      <= 1'b1;
      sda_prev_reg <= 1'b1;
      ls_meta_reg  <= 1'b0;
      ls_reg       <= 1'b0;
    end else begin
      scl_meta_reg <= i_scl;
      scl_reg      <= scl_meta_reg;
      scl_prev_reg <= scl_reg;
      sda_meta_reg <= i_sda;
      sda_reg      <= sda_meta_reg;
      sda_prev_reg <= sda_reg;
      ls_meta_reg  <= i_low_supply;
      ls_reg       <= ls_meta_reg;
    end
  end

  wire scl_rise = scl_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_reg & scl_prev_reg;
  wire scl_high = scl_reg & scl_prev_reg;
  wire bus_start = scl_high & sda_prev_reg & ~sda_reg;
  wire bus_stop = scl_high & ~sda_prev_reg & sda_reg;
  wire rx_done = scl_fall & (bit_cnt_reg == 4'h8);

  function automatic logic [22:0] meas_cycles(input logic hum,
                                              input logic [1:0] res);
    logic [22:0] c;
    c = 23'h000000;
    unique case (res)
      2'b00: c = hum ? 23'(H12_CYC) : 23'(T14_CYC);
      2'b01: c = hum ? 23'(H8_CYC) : 23'(T12_CYC);
      2'b10: c = hum ? 23'(H10_CYC) : 23'(T13_CYC);
      2'b11: c = hum ? 23'(H11_CYC) : 23'(T11_CYC);
    endcase
    return c;
  endfunction

  function automatic logic [13:0] res_mask(input logic hum,
                                           input logic [1:0] res);
    logic [3:0] n;
    n = 4'he;
    unique case (res)
      2'b00: n = hum ? 4'hc : 4'he;
      2'b01: n = hum ? 4'h8 : 4'hc;
      2'b10: n = hum ? 4'ha : 4'hd;
      2'b11: n = hum ? 4'hb : 4'hb;
    endcase
    return 14'h3fff << (4'he - n);
  endfunction

  function automatic logic [7:0] tx_byte(input logic [1:0] idx);
    logic [7:0] b;
    b = res_reg.crc;
    if (tx_ureg_reg) begin
      b = ureg_reg;
    end else if (idx == 2'h0) begin
      b = res_reg.word[15:8];
    end else if (idx == 2'h1) begin
      b = res_reg.word[7:0];
    end
    return b;
  endfunction

  // command and header decode
  wire [7:0] cmd = shift_reg;
  wire addr_hit = (shift_reg[7:1] == `DEV_ADDR) & ~srst_reg;
  wire is_read = shift_reg[0];
  wire cmd_go = (state_reg == sensor_pkg::ST_CMD) & rx_done;
  wire cmd_hum = (cmd == `CMD_H_HOLD) | (cmd == `CMD_H_POLL);
  wire cmd_hold = (cmd == `CMD_T_HOLD) | (cmd == `CMD_H_HOLD);
  wire cmd_meas = cmd_hold | (cmd == `CMD_T_POLL) | (cmd == `CMD_H_POLL);
  wire meas_start = cmd_go & cmd_meas & ~timer_busy;
  wire srst_start = cmd_go & (cmd == `CMD_SRST) & ~timer_busy;
  wire wr_cmd = cmd_go & (cmd == `CMD_WR_UREG);
  wire rd_cmd = cmd_go & (cmd == `CMD_RD_UREG);
  wire cmd_ack = meas_start | srst_start | wr_cmd | rd_cmd;
  wire ureg_wr = (state_reg == sensor_pkg::ST_WDATA) & rx_done;

  wire hdr_go = (state_reg == sensor_pkg::ST_ADDR) & rx_done
                & addr_hit & is_read;
  wire rd_ureg = hdr_go & rd_ureg_pend_reg;
  wire rd_hold = hdr_go & ~rd_ureg_pend_reg & hold_pend_reg & timer_busy;
  // a poll while busy gets no acknowledge
  wire rd_res = hdr_go & ~rd_ureg_pend_reg & ~rd_hold & res_valid_reg;
  wire hdr_ack = rd_ureg | rd_hold | rd_res;
  wire hold_exit = (state_reg == sensor_pkg::ST_HOLD) & res_valid_reg;

  // settings reload applies before the measurement starts
  wire [1:0] eff_res = ureg_reg.no_reload ?
                       {ureg_reg.res_hi, ureg_reg.res_lo} : 2'b00;
  wire meas_end = timer_done & ~srst_reg;

  assign timer_cycles = srst_start ? 23'(SRST_CYC)
                        : meas_cycles(cmd_hum, eff_res);

  wire [13:0] raw = meas_hum_reg ? i_hum_code : i_temp_code;
  assign cap_word = {raw & res_mask(meas_hum_reg, meas_res_reg),
                     meas_hum_reg, 1'b0};

  crc8_unit u_crc (
    .i_word (cap_word),
    .o_crc  (cap_crc)
  );

  meas_timer u_timer (
    .i_clk    (i_core_clk),
    .i_rst_n  (rst_n),
    .i_start  (meas_start | srst_start),
    .i_cycles (timer_cycles),
    .o_busy   (timer_busy),
    .o_done   (timer_done)
  );

  // bus protocol engine
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= sensor_pkg::ST_IDLE;
      after_reg    <= sensor_pkg::ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      byte_idx_reg <= 2'h0;
      last_idx_reg <= 2'h0;
      tx_ureg_reg  <= 1'b0;
      mack_reg     <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= sensor_pkg::ST_IDLE;
    end else if (bus_start) begin
      state_reg   <= sensor_pkg::ST_ADDR;
      bit_cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        sensor_pkg::ST_IDLE: begin
        end
        sensor_pkg::ST_ADDR,
        sensor_pkg::ST_CMD,
        sensor_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (rx_done) begin
            state_reg <= sensor_pkg::ST_IDLE;
            after_reg <= sensor_pkg::ST_IDLE;
            if (state_reg == sensor_pkg::ST_ADDR) begin
              if (addr_hit & ~is_read) begin
                state_reg <= sensor_pkg::ST_ACK;
                after_reg <= sensor_pkg::ST_CMD;
              end else if (hdr_ack) begin
                state_reg    <= sensor_pkg::ST_ACK;
                after_reg    <= rd_hold ? sensor_pkg::ST_HOLD
                                        : sensor_pkg::ST_TX;
                tx_ureg_reg  <= rd_ureg;
                last_idx_reg <= rd_ureg ? 2'h0 : 2'h2;
              end
            end else if (state_reg == sensor_pkg::ST_CMD) begin
              if (cmd_ack) begin
                state_reg <= sensor_pkg::ST_ACK;
                if (wr_cmd) begin
                  after_reg <= sensor_pkg::ST_WDATA;
                end
              end
            end else begin
              state_reg <= sensor_pkg::ST_ACK;
            end
          end
        end
        sensor_pkg::ST_ACK: begin
          if (scl_fall) begin
            state_reg    <= after_reg;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= 2'h0;
            shift_reg    <= tx_byte(2'h0);
          end
        end
        sensor_pkg::ST_HOLD: begin
          if (res_valid_reg) begin
            state_reg    <= sensor_pkg::ST_TX;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= 2'h0;
            shift_reg    <= res_reg.word[15:8];
          end
        end
        sensor_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= sensor_pkg::ST_RACK;
            end else begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        sensor_pkg::ST_RACK: begin
          if (scl_rise) begin
            mack_reg <= ~sda_reg;
          end else if (scl_fall) begin
            if (mack_reg & (byte_idx_reg != last_idx_reg)) begin
              state_reg    <= sensor_pkg::ST_TX;
              bit_cnt_reg  <= 4'h0;
              byte_idx_reg <= byte_idx_reg + 2'h1;
              shift_reg    <= tx_byte(byte_idx_reg + 2'h1);
            end else begin
              state_reg <= sensor_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // keeps SCL low a little after the first bit appears on SDA
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_reg <= 4'h0;
    end else if (hold_exit) begin
      guard_reg <= SETUP_CYC;
    end else if (guard_reg != 4'h0) begin
      guard_reg <= guard_reg - 4'h1;
    end
  end

  // measurement bookkeeping
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_reg          <= '0;
      res_valid_reg    <= 1'b0;
      hold_pend_reg    <= 1'b0;
      rd_ureg_pend_reg <= 1'b0;
      srst_reg         <= 1'b0;
      meas_hum_reg     <= 1'b0;
      meas_res_reg     <= 2'b00;
    end else begin
      if (cmd_go) begin
        rd_ureg_pend_reg <= rd_cmd;
      end else if (rd_ureg) begin
        rd_ureg_pend_reg <= 1'b0;
      end
      if (rd_res | hold_exit | meas_start | srst_start) begin
        res_valid_reg <= 1'b0;
      end
      if (hold_exit | srst_start) begin
        hold_pend_reg <= 1'b0;
      end
      if (meas_start) begin
        hold_pend_reg <= cmd_hold;
        meas_hum_reg  <= cmd_hum;
        meas_res_reg  <= eff_res;
      end
      if (srst_start) begin
        srst_reg <= 1'b1;
      end else if (timer_done) begin
        srst_reg <= 1'b0;
      end
      if (meas_end) begin
        res_reg.word  <= cap_word;
        res_reg.crc   <= cap_crc;
        res_valid_reg <= 1'b1;
      end
    end
  end

  // user register
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ureg_reg <= `UREG_RST;
    end else begin
      if ((meas_start & ~ureg_reg.no_reload) | srst_start) begin
        ureg_reg.res_hi    <= 1'b0;
        ureg_reg.res_lo    <= 1'b0;
        ureg_reg.rsvd      <= `UREG_RSVD_DEF;
        ureg_reg.no_reload <= 1'b1;
      end
      if (ureg_wr) begin
        ureg_reg.res_hi    <= shift_reg[`UREG_RES_HI_BIT];
        ureg_reg.res_lo    <= shift_reg[`UREG_RES_LO_BIT];
        ureg_reg.heater    <= shift_reg[`UREG_HEATER_BIT];
        ureg_reg.no_reload <= shift_reg[`UREG_NORLD_BIT];
      end
      if (meas_end) begin
        ureg_reg.low_supply <= ls_reg;
      end
    end
  end

  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe = (state_reg == sensor_pkg::ST_HOLD)
                    | (guard_reg != 4'h0);
  assign o_sda_oe = (state_reg == sensor_pkg::ST_ACK)
                    | ((state_reg == sensor_pkg::ST_TX)
                       & ~shift_reg[7]);
  assign o_heater_en = ureg_reg.heater;
  assign o_busy = timer_busy;
endmodule
`default_nettype wire

// file: test/i2c_master_model.sv
`include "sensor_defs.svh"
`default_nettype none
module i2c_master_model (
  input  wire logic i_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_pull,
  output logic      o_sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  int stretch_cyc;

  initial begin
    o_scl_pull = 1'b0;
    o_sda_pull = 1'b0;
    stretch_cyc = 0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask

  // one scl period; a held-low clock is waited out
  task automatic xfer(input logic b, output logic r);
    int n;
    n = 0;
    o_sda_pull = ~b;
    tick(2);
    o_scl_pull = 1'b0;
    while (!i_scl && n < 5000) begin
      tick(1);
      n++;
    end
    stretch_cyc += n;
    tick(2);
    r = i_sda;
    tick(2);
    o_scl_pull = 1'b1;
    tick(2);
  endtask

  task automatic start();
    o_sda_pull = 1'b0;
    tick(2);
    o_scl_pull = 1'b0;
    tick(4);
    o_sda_pull = 1'b1;
    tick(4);
    o_scl_pull = 1'b1;
    tick(2);
  endtask

  task automatic stop();
    o_sda_pull = 1'b1;
    tick(2);
    o_scl_pull = 1'b0;
    tick(4);
    o_sda_pull = 1'b0;
    tick(4);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer(b[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      d[i] = r;
    end
    xfer(~ack, r);
  endtask

  task automatic cmd(input logic [7:0] c, input logic pol, output logic ack);
    logic a;
    start();
    wr_byte({`DEV_ADDR, 1'b0}, a);
    wr_byte(c, ack);
    ack = ack & a;
    if (pol)
      tick(1000);
  endtask

  task automatic poll(output logic ack);
    start();
    wr_byte({`DEV_ADDR, 1'b1}, ack);
  endtask
endmodule
`default_nettype wire

// file: test/humidity_temp_sensor_i2c_readout_props.sv
`default_nettype none
module humidity_temp_sensor_i2c_readout_props #(
  parameter int unsigned T14_CYC  = 1,
  parameter int unsigned H12_CYC  = 1,
  parameter int unsigned SRST_CYC = 1
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_heater_en,
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned MM = (T14_CYC > H12_CYC) ? T14_CYC : H12_CYC;
  localparam int unsigned LIM = ((MM > SRST_CYC) ? MM : SRST_CYC) + 8;

  logic [31:0] busy_cnt;
  logic [3:0]  free_cnt;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn)
      busy_cnt <= '0;
    else if (o_busy)
      busy_cnt <= busy_cnt + 32'h1;
    else
      busy_cnt <= '0;
  end

  // cycles of stretching with no measurement running
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn)
      free_cnt <= '0;
    else if (!(o_scl_oe && !o_busy))
      free_cnt <= '0;
    else if (free_cnt != 4'hf)
      free_cnt <= free_cnt + 4'h1;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_meas_end;
    $fell(o_busy) ##0 o_scl_oe;
  endsequence

  chk_scl_drive_low: assert property (o_scl_out == 1'b0)
    else $error("scl driven high");
  chk_sda_drive_low: assert property (o_sda_out == 1'b0)
    else $error("sda driven high");
  chk_stretch_hold: assert property (o_scl_oe && o_busy |=> o_scl_oe)
    else $error("clock released during measurement");
  chk_stretch_release: assert property (s_meas_end |-> ##[1:10] !o_scl_oe)
    else $error("clock not released after measurement");
  chk_stretch_idle: assert property (free_cnt <= 4'h8)
    else $error("clock held with no measurement");
  chk_sda_moves_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("sda changed while scl high");
  chk_reset_quiet: assert property ($rose(i_rstn) |->
    !o_scl_oe && !o_sda_oe && !o_busy && !o_heater_en)
    else $error("outputs active after reset");
  chk_heater_kept: assert property ($rose(o_busy) |-> $stable(o_heater_en))
    else $error("heater changed at command");
  chk_busy_bound: assert property (busy_cnt <= LIM)
    else $error("busy beyond maximum time");
endmodule

bind humidity_temp_sensor_i2c_readout humidity_temp_sensor_i2c_readout_props #(
  .T14_CYC (T14_CYC),
  .H12_CYC (H12_CYC),
  .SRST_CYC(SRST_CYC)
) u_props (
  .i_core_clk (i_core_clk),
  .i_rstn     (i_rstn),
  .i_scl      (i_scl),
  .o_scl_out  (o_scl_out),
  .o_scl_oe   (o_scl_oe),
  .o_sda_out  (o_sda_out),
  .o_sda_oe   (o_sda_oe),
  .o_heater_en(o_heater_en),
  .o_busy     (o_busy)
);
`default_nettype wire

// file: test/humidity_temp_sensor_i2c_readout_tb_top.sv
`include "sensor_defs.svh"
`default_nettype none
module humidity_temp_sensor_i2c_readout_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T14 = 2000;
  localparam int SRST = 600;

  logic        clk, rstn, m_scl, m_sda, scl_oe, sda_oe, low_supply, busy;
  logic        heater_en;
  logic [13:0] temp_code, hum_code;
  int          error_cnt, tests_run, cyc_cnt;
  wire         scl_w;
  wire         sda_w;

  assign scl_w = ~(m_scl | scl_oe);
  assign sda_w = ~(m_sda | sda_oe);

  humidity_temp_sensor_i2c_readout #(
    // other timings stay long; no scenario measures with them
    .T14_CYC(T14), .T13_CYC(1800), .H12_CYC(1900), .H8_CYC(1300),
    .SRST_CYC(SRST)
  ) u_dut (
    .i_core_clk(clk), .i_rstn(rstn), .i_scl(scl_w), .o_scl_out(),
    .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda_out(), .o_sda_oe(sda_oe),
    .i_temp_code(temp_code), .i_hum_code(hum_code),
    .i_low_supply(low_supply), .o_heater_en(heater_en), .o_busy(busy)
  );

  i2c_master_model u_m (
    .i_clk(clk), .i_scl(scl_w), .i_sda(sda_w),
    .o_scl_pull(m_scl), .o_sda_pull(m_sda)
  );

  task automatic check(input string w, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  function automatic logic [15:0] exp_word(input logic h,
                                           input logic [13:0] cd,
                                           input logic [1:0] r);
    int n;
    if (h)
      n = (r == 2'h0) ? 12 : (r == 2'h1) ? 8 : (r == 2'h2) ? 10 : 11;
    else
      n = (r == 2'h0) ? 14 : (r == 2'h1) ? 12 : (r == 2'h2) ? 13 : 11;
    return {cd & ~(14'h3fff >> n), h, 1'b0};
  endfunction

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction

  task automatic rd_ureg(output logic [7:0] v);
    logic a;
    u_m.cmd(`CMD_RD_UREG, 1'b0, a);
    u_m.poll(a);
    u_m.rd_byte(1'b0, v);
    u_m.stop();
  endtask

  task automatic wr_ureg(input logic [1:0] r, input logic ht, nrl);
    logic [7:0] cur;
    logic a;
    rd_ureg(cur);
    u_m.cmd(`CMD_WR_UREG, 1'b0, a);
    u_m.wr_byte({r[1], cur[6:3], ht, nrl, r[0]}, a);
    u_m.stop();
  endtask

  task automatic t_reset();
    logic [7:0] v;
    logic a;
    check("heater", 16'h0, {15'h0, heater_en});
    rd_ureg(v);
    check("ureg", 16'h02, {8'h0, v});
    u_m.start();
    u_m.wr_byte({`DEV_ADDR ^ 7'h01, 1'b0}, a);
    u_m.stop();
    check("foreign ack", 16'h0, {15'h0, a});
    $display("test reset done");
  endtask

  task automatic t_poll();
    logic [7:0] hi, lo, v;
    logic a;
    int n;
    wr_ureg(2'h1, 1'b1, 1'b1);
    check("heater on", 16'h1, {15'h0, heater_en});
    low_supply = 1'b1;
    hum_code = 14'h2e91;
    u_m.cmd(`CMD_H_POLL, 1'b1, a);
    u_m.stop();
    check("cmd ack", 16'h1, {15'h0, a});
    u_m.poll(a);
    check("early poll", 16'h0, {15'h0, a});
    n = 0;
    while (a !== 1'b1 && n < 40) begin
      u_m.stop();
      u_m.tick(50);
      u_m.poll(a);
      n++;
    end
    check("poll ack", 16'h1, {15'h0, a});
    u_m.rd_byte(1'b1, hi);
    u_m.rd_byte(1'b0, lo);
    u_m.stop();
    check("sda free", 16'h0, {15'h0, sda_oe});
    check("hum word", exp_word(1'b1, hum_code, 2'h1), {hi, lo});
    check("raw hum", {hum_code & 14'h3fc0, 2'b00}, {hi, lo} & 16'hfffc);
    rd_ureg(v);
    check("ureg low", 16'h47, {8'h0, v});
    $display("test poll done");
  endtask

  task automatic t_hold();
    logic [7:0] hi, lo, c, v;
    logic a;
    wr_ureg(2'h3, 1'b1, 1'b0);
    u_m.cmd(`CMD_T_HOLD, 1'b0, a);
    u_m.poll(a);
    check("hold ack", 16'h1, {15'h0, a});
    u_m.stretch_cyc = 0;
    u_m.rd_byte(1'b1, hi);
    u_m.rd_byte(1'b1, lo);
    u_m.rd_byte(1'b0, c);
    u_m.stop();
    check("stretch", 16'h1, {15'h0, u_m.stretch_cyc > T14 - 400});
    check("max time", 16'h1, {15'h0, u_m.stretch_cyc <= T14 + 20});
    check("temp word", exp_word(1'b0, temp_code, 2'h0), {hi, lo});
    check("temp crc", {8'h0, crc8({hi, lo})}, {8'h0, c});
    check("raw temp", {temp_code, 2'b00}, {hi, lo} & 16'hfffc);
    rd_ureg(v);
    check("ureg reload", 16'h46, {8'h0, v});
    $display("test hold done");
  endtask

  task automatic t_srst();
    logic [7:0] v, hi, lo;
    logic a;
    int n;
    wr_ureg(2'h2, 1'b1, 1'b1);
    low_supply = 1'b0;
    temp_code = 14'h1c3e;
    u_m.cmd(`CMD_T_POLL, 1'b1, a);
    u_m.stop();
    a = 1'b0;
    n = 0;
    while (a !== 1'b1 && n < 40) begin
      u_m.tick(50);
      u_m.poll(a);
      if (a !== 1'b1)
        u_m.stop();
      n++;
    end
    check("t13 ack", 16'h1, {15'h0, a});
    u_m.rd_byte(1'b1, hi);
    u_m.rd_byte(1'b0, lo);
    u_m.stop();
    check("t13 word", exp_word(1'b0, temp_code, 2'h2), {hi, lo});
    u_m.cmd(`CMD_SRST, 1'b0, a);
    u_m.stop();
    check("busy", 16'h1, {15'h0, busy});
    u_m.start();
    u_m.wr_byte({`DEV_ADDR, 1'b0}, a);
    u_m.stop();
    check("addr in reset", 16'h0, {15'h0, a});
    n = 0;
    while (busy !== 1'b0 && n < SRST) begin
      u_m.tick(1);
      n++;
    end
    check("reset length", 16'h1, {15'h0, n < SRST});
    rd_ureg(v);
    check("ureg srst", 16'h06, {8'h0, v});
    $display("test soft reset done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      $display("mismatch run length expected end seen hang");
      give_verdict();
    end
  end

  initial begin
    rstn = 1'b0;
    low_supply = 1'b0;
    temp_code = 14'h2a5b;
    hum_code = 14'h18d7;
    error_cnt = 0;
    tests_run = 0;
    cyc_cnt = 0;
    repeat (12) @(posedge clk);
    #2;
    rstn = 1'b1;
    u_m.tick(8);
    t_reset();
    t_poll();
    t_hold();
    t_srst();
    give_verdict();
  end
endmodule
`default_nettype wire
